// >>> src/cct_pkg.sv
// Constants, enumerations and shared types of the cycle timing and address decode core
package cct_pkg;
   localparam int unsigned STATES_PER_CYCLE = 6;
   localparam logic [2:0]  ALE_FIRST_STATE  = 3'h1;
   localparam logic [2:0]  ALE_SECOND_STATE = 3'h4;
   localparam logic [2:0]  FETCH_B_STATE    = 3'h4;
   localparam logic [7:0]  SP_RESET         = 8'h07;
   localparam logic [7:0]  PSW_RESET        = 8'h00;
   localparam logic [7:0]  B_RESET          = 8'h00;
   localparam logic [15:0] PC_RESET         = 16'h0000;
   localparam int unsigned BANK_SEL_LSB     = 3;
   localparam int unsigned BANK_SEL_MSB     = 4;
   localparam logic [7:0]  BANK_TOP         = 8'h1F;
   localparam logic [7:0]  BIT_AREA_LO      = 8'h20;
   localparam logic [7:0]  BIT_AREA_HI      = 8'h2F;
   localparam logic [7:0]  LOWER_TOP        = 8'h7F;
   localparam logic [15:0] ONCHIP_EXTENDED_RAM_BASE        = 16'hF400;
   localparam logic [15:0] BOOT_TOP         = 16'h01FF;
   localparam int unsigned BOOT_BYTES       = 512;
   localparam int unsigned IDATA_BYTES      = 256;
   localparam int unsigned ONCHIP_EXTENDED_RAM_BYTES       = 3072;
   localparam int unsigned SPECIAL_BYTES    = 128;
   localparam int unsigned CTRL_ONCHIP_EXTENDED_RAM_BIT    = 0;
   localparam int unsigned CTRL_BOOT_BIT    = 1;
   localparam logic [3:0]  REG_SP           = 4'h0;
   localparam logic [3:0]  REG_B            = 4'h1;
   localparam logic [3:0]  REG_PSW          = 4'h2;
   localparam logic [3:0]  REG_CTRL         = 4'h3;
   localparam logic [3:0]  REG_STATUS       = 4'h4;
   localparam logic [3:0]  REG_PC_LO        = 4'h5;
   localparam logic [3:0]  REG_PC_HI        = 4'h6;
   localparam logic [3:0]  REG_OPCODE       = 4'h7;
   typedef enum logic [1:0] {
      OP_ONE_CYCLE = 2'h0,
      OP_TWO_CYCLE = 2'h1,
      OP_EXT_MOVE  = 2'h2,
      OP_MUL_DIV   = 2'h3
   } cct_op_class_t;
   typedef enum logic [1:0] {
      CYC_FIRST  = 2'h0,
      CYC_SECOND = 2'h1,
      CYC_THIRD  = 2'h3,
      CYC_FOURTH = 2'h2
   } cct_cyc_t;
   typedef struct packed {
      logic bank;
      logic bit_area;
      logic lower;
      logic upper;
      logic special;
      logic onchip_extended_ram;
      logic xext;
      logic boot;
   } cct_sel_t;
endpackage

// >>> src/cct_tim_if.sv
// State and phase strobes passed from the timing generator to the sequencer
`timescale 1ns/100ps
interface cct_tim_if;
   logic [2:0] st;
   logic       ph2;
   logic       osc;
   logic       ale;
   logic       cyc_end;
   modport src (output st, output ph2, output osc, output ale, output cyc_end);
   modport snk (input st, input ph2, input osc, input ale, input cyc_end);
endinterface

// >>> src/cct_timing.sv
// Machine cycle state and phase generator
`timescale 1ns/100ps
module cct_timing #(
   parameter int unsigned STATES = cct_pkg::STATES_PER_CYCLE
) (
   input  wire logic clk,
   input  wire logic rstn,
   cct_tim_if.src    tim
);
   localparam int unsigned LAST = 2 * STATES - 1;
   localparam int unsigned IW   = $clog2(2 * STATES);

   // ALE and fetch placement assume a cycle of five to seven states
   if (STATES < 5 || STATES > 7) begin : g_bad
      $error("cct_timing: unsupported state count");
   end

   typedef struct packed {
      logic [IW-1:0] idx;
      logic [2:0]    st;
      logic          ph2;
      logic          osc;
      logic          ale;
      logic          cyc_end;
   } cct_tim_state_t;

   cct_tim_state_t q;
   cct_tim_state_t n;

   always_comb begin
      n = q;
      n.idx = (q.idx == IW'(LAST)) ? '0 : q.idx + 1'b1;
      n.st = 3'(n.idx >> 1) + 3'h1;
      n.ph2 = n.idx[0];
      n.osc = ~n.idx[0];
      n.ale = (n.st == cct_pkg::ALE_FIRST_STATE && n.ph2)
           || (n.st == cct_pkg::ALE_FIRST_STATE + 3'h1 && !n.ph2)
           || (n.st == cct_pkg::ALE_SECOND_STATE && n.ph2)
           || (n.st == cct_pkg::ALE_SECOND_STATE + 3'h1 && !n.ph2);
      n.cyc_end = (n.idx == IW'(LAST));
   end

   // Reset parks on the last phase so the first edge after release opens state one
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         q <= '0;
         q.idx <= IW'(LAST);
         q.st <= 3'(STATES);
         q.ph2 <= 1'b1;
      end else begin
         q <= n;
      end
   end

   assign tim.st = q.st;
   assign tim.ph2 = q.ph2;
   assign tim.osc = q.osc;
   assign tim.ale = q.ale;
   assign tim.cyc_end = q.cyc_end;
endmodule

// >>> src/cct_decode.sv
// Combinational decode of internal data, external data and code addresses
`timescale 1ns/100ps
module cct_decode (
   input  wire logic              [7:0]  idata_addr,
   input  wire logic                     idata_indirect,
   input  wire logic              [15:0] xdata_addr,
   input  wire logic                     xdata_move,
   input  wire logic                     onchip_extended_ram_on,
   input  wire logic                     boot_mode,
   input  wire logic              [15:0] code_addr,
   output cct_pkg::cct_sel_t             sel,
   output logic                   [11:0] onchip_extended_ram_off
);
   logic high_half;
   logic in_onchip_extended_ram;

   always_comb begin
      high_half = (idata_addr > cct_pkg::LOWER_TOP);
      in_onchip_extended_ram = (xdata_addr >= cct_pkg::ONCHIP_EXTENDED_RAM_BASE)
             && (32'(xdata_addr - cct_pkg::ONCHIP_EXTENDED_RAM_BASE) < cct_pkg::ONCHIP_EXTENDED_RAM_BYTES);
      sel = '0;
      sel.bank = (idata_addr <= cct_pkg::BANK_TOP);
      sel.bit_area = (idata_addr >= cct_pkg::BIT_AREA_LO)
                  && (idata_addr <= cct_pkg::BIT_AREA_HI);
      sel.lower = !high_half;
      sel.upper = high_half && idata_indirect;
      sel.special = high_half && !idata_indirect;
      // Only external data moves reach the extended RAM; other accesses see neither side
      sel.onchip_extended_ram = xdata_move && onchip_extended_ram_on && in_onchip_extended_ram;
      sel.xext = xdata_move && !(onchip_extended_ram_on && in_onchip_extended_ram);
      sel.boot = boot_mode && (code_addr <= cct_pkg::BOOT_TOP);
      onchip_extended_ram_off = sel.onchip_extended_ram ? 12'(xdata_addr - cct_pkg::ONCHIP_EXTENDED_RAM_BASE) : 12'h000;
   end
endmodule

// >>> src/cct_core.sv
// Instruction cycle sequencer, stack pointer, auxiliary register and memory selects
//
// Design decisions made here: the address map and the address-and-strobe port.
`timescale 1ns/100ps
module cct_core (
   input  wire logic                     clk,
   input  wire logic                     rstn,
   input  wire logic              [3:0]  reg_addr,
   input  wire logic              [7:0]  reg_wdata,
   input  wire logic                     reg_wr,
   input  wire logic                     reg_rd,
   output logic                   [7:0]  reg_rdata,
   output logic                   [15:0] code_addr,
   output logic                          code_rd,
   output logic                          code_boot_sel,
   input  wire logic              [7:0]  code_data,
   output logic                   [7:0]  opcode,
   output logic                   [7:0]  operand,
   input  wire cct_pkg::cct_op_class_t   op_class,
   input  wire logic                     op_two_byte,
   output logic                          instr_done,
   output cct_pkg::cct_cyc_t             machine_cycle,
   output logic                          oscillator_signal,
   output logic                          ale,
   input  wire logic                     stack_push,
   input  wire logic                     stack_pop,
   output logic                   [7:0]  stack_addr,
   output logic                          stack_we,
   output logic                          stack_re,
   output logic                   [7:0]  b_operand,
   input  wire logic              [7:0]  b_result,
   input  wire logic              [2:0]  reg_sel,
   output logic                   [7:0]  gpr_addr,
   output logic                   [7:0]  pointer_register_zero,
   output logic                   [7:0]  pointer_register_one,
   input  wire logic              [7:0]  idata_addr,
   input  wire logic                     idata_indirect,
   output cct_pkg::cct_sel_t             mem_sel,
   input  wire logic              [15:0] xdata_addr,
   output logic                          xdata_strobe,
   output logic                   [11:0] onchip_extended_ram_offset,
   input  wire logic                     hardware_powerdown_input,
   input  wire logic                     boot_mode_pin
);
   typedef struct packed {
      logic              hpd_meta;
      logic              hpd;
      logic              bmp_meta;
      logic              bmp;
      logic              started;
      logic              boot_mode;
      logic              onchip_extended_ram_on;
      logic [7:0]        sp;
      logic [7:0]        b;
      logic [7:0]        program_status_word;
      logic [7:0]        ir;
      logic [7:0]        operand;
      logic [15:0]       pc;
      logic [15:0]       code_addr;
      logic              code_rd;
      logic              code_back;
      logic              boot_sel;
      cct_pkg::cct_cyc_t cyc;
      logic              done;
      logic              xstrobe;
      logic [7:0]        stack_addr;
      logic              stack_we;
      logic              stack_re;
      logic [7:0]        gpr_addr;
      logic [7:0]        ptr0;
      logic [7:0]        ptr1;
      cct_pkg::cct_sel_t sel;
      logic [11:0]       onchip_extended_ram_off;
      logic [7:0]        rdata;
   } cct_core_state_t;

   cct_core_state_t   q;
   cct_core_state_t   n;
   cct_pkg::cct_sel_t dsel;
   cct_pkg::cct_sel_t csel;
   logic [11:0]       dxoff;
   logic [1:0]        bank;
   logic              last_cyc;
   logic              ext_move_second;
   cct_pkg::cct_cyc_t next_cyc;
   logic              sw_wr_sp;

   cct_tim_if tim ();

   cct_timing #(
      .STATES (cct_pkg::STATES_PER_CYCLE)
   ) u_timing (
      .clk  (clk),
      .rstn (rstn),
      .tim  (tim.src)
   );

   // Data side decode on the caller's addresses
   cct_decode u_dec_data (
      .idata_addr     (idata_addr),
      .idata_indirect (idata_indirect),
      .xdata_addr     (xdata_addr),
      .xdata_move     (q.xstrobe),
      .onchip_extended_ram_on        (q.onchip_extended_ram_on),
      .boot_mode      (q.boot_mode),
      .code_addr      (q.pc),
      .sel            (dsel),
      .onchip_extended_ram_off       (dxoff)
   );

   // Code side decode on the program counter, so the select leaves with the address
   cct_decode u_dec_code (
      .idata_addr     (8'h00),
      .idata_indirect (1'b0),
      .xdata_addr     (16'h0000),
      .xdata_move     (1'b0),
      .onchip_extended_ram_on        (1'b0),
      .boot_mode      (q.boot_mode),
      .code_addr      (q.pc),
      .sel            (csel),
      .onchip_extended_ram_off       ()
   );

   always_comb begin
      n = q;
      bank = q.program_status_word[cct_pkg::BANK_SEL_MSB:cct_pkg::BANK_SEL_LSB];
      unique case (op_class)
         cct_pkg::OP_ONE_CYCLE: last_cyc = (q.cyc == cct_pkg::CYC_FIRST);
         cct_pkg::OP_TWO_CYCLE: last_cyc = (q.cyc == cct_pkg::CYC_SECOND);
         cct_pkg::OP_EXT_MOVE:  last_cyc = (q.cyc == cct_pkg::CYC_SECOND);
         cct_pkg::OP_MUL_DIV:   last_cyc = (q.cyc == cct_pkg::CYC_FOURTH);
      endcase
      unique case (q.cyc)
         cct_pkg::CYC_FIRST:  next_cyc = cct_pkg::CYC_SECOND;
         cct_pkg::CYC_SECOND: next_cyc = cct_pkg::CYC_THIRD;
         cct_pkg::CYC_THIRD:  next_cyc = cct_pkg::CYC_FOURTH;
         cct_pkg::CYC_FOURTH: next_cyc = cct_pkg::CYC_FIRST;
      endcase
      // Before the first cycle the class input is meaningless, so start clean
      if (last_cyc || !q.started) begin
         next_cyc = cct_pkg::CYC_FIRST;
      end
      ext_move_second = (q.cyc == cct_pkg::CYC_SECOND)
                     && (op_class == cct_pkg::OP_EXT_MOVE);

      // Pin inputs: second stage only is read by logic
      n.hpd_meta = hardware_powerdown_input;
      n.hpd = q.hpd_meta;
      n.bmp_meta = boot_mode_pin;
      n.bmp = q.bmp_meta;
      // Chipmode strap is caught at reset release and while power-down is held
      if (!q.started || q.hpd) begin
         n.boot_mode = q.bmp;
      end

      n.code_rd = 1'b0;
      // Memory answers one cycle after the strobe, so the strobe is carried on to meet its byte
      n.code_back = q.code_rd;
      n.done = 1'b0;
      n.stack_we = 1'b0;
      n.stack_re = 1'b0;

      // Machine cycle boundary at the end of state six phase two
      if (tim.cyc_end) begin
         n.started = 1'b1;
         n.done = last_cyc && q.started;
         n.cyc = next_cyc;
         if (last_cyc && q.started && op_class == cct_pkg::OP_MUL_DIV) begin
            n.b = b_result;
         end
         n.xstrobe = (next_cyc == cct_pkg::CYC_SECOND)
                  && (op_class == cct_pkg::OP_EXT_MOVE) && q.started;
         if (!n.xstrobe) begin
            n.code_rd = 1'b1;
            n.code_addr = q.pc;
            n.boot_sel = csel.boot;
         end
      end

      // State four fetch, skipped in the second cycle of an external move
      // No fetch before the first cycle boundary: there is no instruction to feed yet
      if (tim.st == cct_pkg::FETCH_B_STATE - 3'h1 && tim.ph2 && !ext_move_second
          && q.started) begin
         n.code_rd = 1'b1;
         n.code_addr = q.pc;
         n.boot_sel = csel.boot;
      end

      // Returned code bytes are consumed only in the first machine cycle
      if (q.code_back && q.cyc == cct_pkg::CYC_FIRST && tim.ph2) begin
         if (tim.st == 3'h1) begin
            n.ir = code_data;
            n.pc = q.pc + 16'h0001;
         end else if (tim.st == cct_pkg::FETCH_B_STATE && op_two_byte) begin
            n.operand = code_data;
            n.pc = q.pc + 16'h0001;
         end
      end

      // Push takes priority when both arrive together; the pop is dropped
      sw_wr_sp = reg_wr && reg_addr == cct_pkg::REG_SP;
      if (stack_push) begin
         n.sp = q.sp + 8'h01;
         n.stack_addr = q.sp + 8'h01;
         n.stack_we = 1'b1;
      end else if (stack_pop) begin
         n.stack_addr = q.sp;
         n.stack_re = 1'b1;
         n.sp = q.sp - 8'h01;
      end else if (sw_wr_sp) begin
         n.sp = reg_wdata;
      end

      if (reg_wr) begin
         unique case (reg_addr)
            cct_pkg::REG_B: begin
               n.b = reg_wdata;
            end
            cct_pkg::REG_PSW: begin
               n.program_status_word = reg_wdata;
            end
            cct_pkg::REG_CTRL: begin
               if (reg_wdata[cct_pkg::CTRL_ONCHIP_EXTENDED_RAM_BIT]) begin
                  n.onchip_extended_ram_on = 1'b1;
               end
            end
            default: begin
            end
         endcase
      end
      // Software has no way to clear it; only power-down or reset do
      if (q.hpd) begin
         n.onchip_extended_ram_on = 1'b0;
      end

      n.gpr_addr = {3'h0, bank, reg_sel};
      n.ptr0 = {3'h0, bank, 3'h0};
      n.ptr1 = {3'h0, bank, 3'h1};
      n.sel = dsel;
      n.sel.boot = q.boot_sel;
      n.onchip_extended_ram_off = dxoff;

      n.rdata = 8'h00;
      if (reg_rd) begin
         unique case (reg_addr)
            cct_pkg::REG_SP:     n.rdata = q.sp;
            cct_pkg::REG_B:      n.rdata = q.b;
            cct_pkg::REG_PSW:    n.rdata = q.program_status_word;
            cct_pkg::REG_CTRL:   n.rdata = {6'h00, q.boot_mode, q.onchip_extended_ram_on};
            cct_pkg::REG_STATUS: n.rdata = {2'h0, q.cyc, tim.st, tim.ph2};
            cct_pkg::REG_PC_LO:  n.rdata = q.pc[7:0];
            cct_pkg::REG_PC_HI:  n.rdata = q.pc[15:8];
            cct_pkg::REG_OPCODE: n.rdata = q.ir;
            default:             n.rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         q <= '0;
         q.sp <= cct_pkg::SP_RESET;
         q.program_status_word <= cct_pkg::PSW_RESET;
         q.b <= cct_pkg::B_RESET;
         q.pc <= cct_pkg::PC_RESET;
         q.cyc <= cct_pkg::CYC_FIRST;
      end else begin
         q <= n;
      end
   end

   assign reg_rdata = q.rdata;
   assign code_addr = q.code_addr;
   assign code_rd = q.code_rd;
   // External code is selected whenever boot select is low; the board keeps the source pin low
   assign code_boot_sel = q.boot_sel;
   assign opcode = q.ir;
   assign operand = q.operand;
   assign instr_done = q.done;
   assign machine_cycle = q.cyc;
   assign oscillator_signal = tim.osc;
   assign ale = tim.ale;
   assign stack_addr = q.stack_addr;
   assign stack_we = q.stack_we;
   assign stack_re = q.stack_re;
   assign b_operand = q.b;
   assign gpr_addr = q.gpr_addr;
   assign pointer_register_zero = q.ptr0;
   assign pointer_register_one = q.ptr1;
   assign mem_sel = q.sel;
   assign xdata_strobe = q.xstrobe;
   assign onchip_extended_ram_offset = q.onchip_extended_ram_off;
endmodule

// >>> dv/cct_props.sv
// Port-level properties of the cycle timing and decode core
`timescale 1ns/100ps
module cct_props (
   input wire logic              clk,
   input wire logic              rstn,
   input wire logic              oscillator_signal,
   input wire logic              ale,
   input wire logic              code_rd,
   input wire logic              instr_done,
   input wire logic              stack_we,
   input wire logic              stack_re,
   input wire logic       [7:0]  stack_addr,
   input wire logic       [2:0]  reg_sel,
   input wire logic       [7:0]  gpr_addr,
   input wire logic       [7:0]  pointer_register_zero,
   input wire logic       [7:0]  pointer_register_one,
   input wire logic       [7:0]  idata_addr,
   input wire logic              idata_indirect,
   input wire cct_pkg::cct_sel_t mem_sel,
   input wire logic       [15:0] xdata_addr,
   input wire logic              xdata_strobe,
   input wire logic       [11:0] onchip_extended_ram_offset
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   // Twelve clocks is beyond a short repetition, so the strobe is counted
   logic [4:0] xs_cnt;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         xs_cnt <= 5'h00;
      end else begin
         xs_cnt <= xdata_strobe ? xs_cnt + 5'h01 : 5'h00;
      end
   end
   property p_osc; rstn |=> oscillator_signal != $past(oscillator_signal); endproperty
   a_osc: assert property (p_osc) else $error("phase did not alternate");
   property p_ale; $rose(ale) |-> !oscillator_signal ##1 (ale && oscillator_signal) ##1 !ale;
   endproperty
   a_ale: assert property (p_ale) else $error("address strobe shape wrong");
   property p_cyc; $rose(ale) |-> ##6 $rose(ale); endproperty
   a_cyc: assert property (p_cyc) else $error("strobe spacing not six");
   property p_fetch; code_rd |-> oscillator_signal ##1 $rose(ale); endproperty
   a_fetch: assert property (p_fetch) else $error("fetch off its state");
   property p_done; instr_done |-> (code_rd && oscillator_signal) ##1 !instr_done; endproperty
   a_done: assert property (p_done) else $error("completion misplaced");
   property p_push; stack_we ##1 stack_we |-> stack_addr == $past(stack_addr) + 8'h01; endproperty
   a_push: assert property (p_push) else $error("push address not incremented");
   property p_pop; stack_re ##1 stack_re |-> stack_addr == $past(stack_addr) - 8'h01; endproperty
   a_pop: assert property (p_pop) else $error("pop address not decremented");
   property p_ptr; rstn |=> gpr_addr[2:0] == $past(reg_sel)
      && pointer_register_one == (pointer_register_zero | 8'h01)
      && (pointer_register_zero & 8'hE7) == 8'h00; endproperty
   a_ptr: assert property (p_ptr) else $error("bank register address wrong");
   property p_sel; (mem_sel.upper || mem_sel.special) |->
      $past(idata_addr) > 8'h7F && mem_sel.upper == $past(idata_indirect); endproperty
   a_sel: assert property (p_sel) else $error("upper area select wrong");
   property p_onchip_extended_ram; mem_sel.onchip_extended_ram |-> !mem_sel.xext && $past(xdata_addr) >= 16'hF400
      && onchip_extended_ram_offset == 12'($past(xdata_addr) - 16'hF400); endproperty
   a_onchip_extended_ram: assert property (p_onchip_extended_ram) else $error("extended ram decode wrong");
   property p_xnof; xdata_strobe |-> !code_rd; endproperty
   a_xnof: assert property (p_xnof) else $error("fetch during data move");
   property p_xlen; $fell(xdata_strobe) |-> xs_cnt == 5'h0C; endproperty
   a_xlen: assert property (p_xlen) else $error("data strobe length wrong");
endmodule

// >>> dv/cct_code_mem.sv
// External code memory answering one cycle after each fetch
`timescale 1ns/100ps
module cct_code_mem (
   input  wire logic        clk,
   input  wire logic [15:0] code_addr,
   input  wire logic        code_rd,
   output logic      [7:0]  code_data
);
   logic [7:0] mem [0:255];
   initial code_data = 8'h00;
   // Every fetch is served externally; between fetches the bus flips so stale data never passes
   always @(posedge clk) begin
      code_data <= code_rd ? mem[code_addr[7:0]] : ~code_data;
   end
endmodule

// >>> dv/tb_cpu_cycle_timing_memory_map.sv
// Self-checking bench for the cycle timing and decode core
`timescale 1ns/100ps
module tb_cpu_cycle_timing_memory_map;
   logic clk = 1'b0, rstn = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic stack_push = 1'b0, stack_pop = 1'b0, idata_indirect = 1'b0;
   logic boot_mode_pin = 1'b0, hardware_powerdown_input = 1'b0, rd_d = 1'b0, seen = 1'b0;
   logic code_rd, code_boot_sel, instr_done, stack_we, stack_re, op_two_byte;
   logic [2:0] reg_sel = 3'h0;
   logic [3:0] reg_addr = 4'h0;
   logic [7:0] reg_wdata = 8'h00, b_result = 8'h00, idata_addr = 8'h00, bv, opd, b_op;
   logic [7:0] reg_rdata, code_data, opcode, operand, stack_addr, pointer_register_zero;
   logic [15:0] code_addr, xdata_addr = 16'h0000;
   logic [31:0] r, e;
   logic [31:0] rq[$], sq[$], iq[$];
   int seed = 32'h2b44f432;
   int fails = 0, n_checks = 0, ncyc = 0, nfet = 0;
   cct_pkg::cct_op_class_t op_class;
   // Stand-in for the outside opcode decoder: low bits give class, bit 2 a second byte
   assign op_class = cct_pkg::cct_op_class_t'(opcode[1:0]);
   assign op_two_byte = opcode[2];
   cct_core dut (
      .clk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .code_addr, .code_rd,
      .code_boot_sel, .code_data, .opcode, .operand, .op_class, .op_two_byte, .instr_done,
      .machine_cycle(), .oscillator_signal(), .ale(), .stack_push, .stack_pop, .stack_addr,
      .stack_we, .stack_re, .b_operand(b_op), .b_result, .reg_sel, .gpr_addr(),
      .pointer_register_zero, .pointer_register_one(), .idata_addr, .idata_indirect,
      .mem_sel(), .xdata_addr, .xdata_strobe(), .onchip_extended_ram_offset(), .hardware_powerdown_input,
      .boot_mode_pin
   );
   cct_code_mem mem_u (.clk, .code_addr, .code_rd, .code_data);
   always #2.5 clk = ~clk;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [7:0] x);
      @(posedge clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      rq.push_back({24'h0, x});
      @(posedge clk);
      reg_rd <= 1'b0;
   endtask
   task automatic stk(input logic p, input logic [7:0] x);
      @(posedge clk);
      stack_push <= p;
      stack_pop <= !p;
      sq.push_back({23'h0, p, x});
   endtask
   task automatic stop_test();
      $display("checks=%0d fails=%0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Decode inputs wander every cycle, biased so half the external data addresses land in the extended RAM window
   always @(posedge clk) begin
      rd_d <= reg_rd;
      r = $random(seed);
      reg_sel <= r[2:0];
      idata_indirect <= r[3];
      idata_addr <= r[15:8];
      xdata_addr <= r[4] ? 16'hF400 + {4'h0, r[27:16] % 12'hC00} : r[31:16];
   end
   always @(negedge clk) begin
      if (rd_d) chk({24'h0, reg_rdata}, rq.pop_front());
      if (stack_we || stack_re) chk({23'h0, stack_we, stack_addr}, sq.pop_front());
      if (!rstn) begin
         seen = 1'b0;
      end else if (instr_done || (!seen && code_rd)) begin
         if (seen && iq.size() > 0) begin
            e = iq.pop_front();
            chk({ncyc[7:0], nfet[7:0], opcode, opcode[2] ? operand : 8'h00}, e);
         end
         seen = 1'b1;
         ncyc = 1;
         nfet = code_rd;
      end else begin
         ncyc++;
         nfet += code_rd;
      end
   end
   initial begin
      bv = $random(seed);
      opd = $random(seed);
      b_result = $random(seed);
      for (int i = 0; i < 256; i++) mem_u.mem[i] = 8'h00;
      mem_u.mem[1] = 8'h04;
      mem_u.mem[2] = opd;
      mem_u.mem[3] = 8'h01;
      mem_u.mem[4] = 8'h02;
      mem_u.mem[5] = 8'h03;
      iq.push_back({8'h0C, 8'h02, 8'h00, 8'h00});
      iq.push_back({8'h0C, 8'h02, 8'h04, opd});
      iq.push_back({8'h18, 8'h04, 8'h01, 8'h00});
      iq.push_back({8'h18, 8'h02, 8'h02, 8'h00});
      iq.push_back({8'h30, 8'h08, 8'h03, 8'h00});
      iq.push_back({8'h0C, 8'h02, 8'h00, 8'h00});
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      wr(cct_pkg::REG_CTRL, 8'h01);
      wr(cct_pkg::REG_CTRL, 8'h00);
      rd(cct_pkg::REG_CTRL, 8'h01);
      rd(cct_pkg::REG_SP, cct_pkg::SP_RESET);
      wr(cct_pkg::REG_B, bv);
      rd(cct_pkg::REG_B, bv);
      rd(4'hC, 8'h00);
      stk(1'b1, 8'h08);
      stk(1'b1, 8'h09);
      stk(1'b0, 8'h09);
      stk(1'b0, 8'h08);
      @(posedge clk);
      stack_push <= 1'b0;
      stack_pop <= 1'b0;
      rd(cct_pkg::REG_SP, 8'h07);
      for (int b = 0; b < 4; b++) begin
         wr(cct_pkg::REG_PSW, 8'(b << 3));
         repeat (3) @(posedge clk);
         @(negedge clk);
         chk({24'h0, pointer_register_zero}, 32'(b << 3));
      end
      // Long enough for the four-cycle multiply to finish
      repeat (150) @(posedge clk);
      rd(cct_pkg::REG_B, b_result);
      chk({24'h0, b_op}, {24'h0, b_result});
      chk(iq.size(), 32'h0);
      hardware_powerdown_input <= 1'b1;
      repeat (4) @(posedge clk);
      hardware_powerdown_input <= 1'b0;
      repeat (4) @(posedge clk);
      rd(cct_pkg::REG_CTRL, 8'h00);
      boot_mode_pin <= 1'b1;
      repeat (4) @(posedge clk);
      rstn <= 1'b0;
      repeat (5) @(posedge clk);
      rstn <= 1'b1;
      for (int i = 0; i < 20 && code_rd !== 1'b1; i++) @(negedge clk);
      chk({15'h0, code_boot_sel, code_addr}, 32'h0001_0000);
      rd(cct_pkg::REG_CTRL, 8'h02);
      rd(cct_pkg::REG_SP, cct_pkg::SP_RESET);
      repeat (4) @(posedge clk);
      stop_test();
   end
   // The sequence needs a few hundred cycles; this allows several times that
   initial begin
      #10000;
      fails++;
      stop_test();
   end
endmodule
bind cct_core cct_props u_props (
   .clk, .rstn, .oscillator_signal, .ale, .code_rd, .instr_done, .stack_we, .stack_re,
   .stack_addr, .reg_sel, .gpr_addr, .pointer_register_zero, .pointer_register_one,
   .idata_addr, .idata_indirect, .mem_sel, .xdata_addr, .xdata_strobe, .onchip_extended_ram_offset
);
